// ==== hw/dcc_pkg.sv ====
// Purpose: Shared constants for the dual comparator digital control block.
// Assumes: Avalon-MM byte addressing derived from printed register indices.
// Notes: Byte address of a register is four times its index.
package dcc_pkg;
	localparam logic [7:0] AUX_IDX = 8'h97;
	localparam logic [7:0] MAIN_IDX = 8'h9c;
	localparam logic [7:0] FLAG_IDX = 8'ha0;
	localparam logic [7:0] ENA_IDX = 8'ha1;
	localparam logic [7:0] PIN_IDX = 8'ha2;
	localparam logic [9:0] AUX_ADDR = {AUX_IDX, 2'b00};
	localparam logic [9:0] MAIN_ADDR = {MAIN_IDX, 2'b00};
	localparam logic [9:0] FLAG_ADDR = {FLAG_IDX, 2'b00};
	localparam logic [9:0] ENA_ADDR = {ENA_IDX, 2'b00};
	localparam logic [9:0] PIN_ADDR = {PIN_IDX, 2'b00};
	localparam int MAIN_OUT2_POS = 7;
	localparam int MAIN_OUT1_POS = 6;
	localparam int MAIN_INV2_POS = 5;
	localparam int MAIN_INV1_POS = 4;
	localparam int MAIN_CIS_POS = 3;
	localparam int AUX_GSS_POS = 1;
	localparam int AUX_SYNC_POS = 0;
	localparam int FLAG2_POS = 6;
	localparam int FLAG1_POS = 5;
	localparam int ENA_PERIPHERAL_IRQ_ENABLE_POS = 0;
	localparam int ENA_GIE_POS = 1;
	localparam int ENA_OE_POS = 2;
	localparam logic [5:0] MAIN_RESET = 6'h00;
	localparam logic [1:0] AUX_RESET = 2'h2;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] MODE_OFF = 3'h7;
	localparam logic [7:0] MODE_PINS1 = 8'h3c;
	localparam logic [7:0] MODE_PINS2 = 8'h3e;
	localparam int SETTLE_NS = 10000;
	localparam int CLK_NS = 10;
	localparam int SETTLE_CYC = SETTLE_NS / CLK_NS;
endpackage : dcc_pkg

// ==== hw/dcc_top.sv ====
// Purpose: Digital control of a two-comparator module with gate and flags.
// Assumes: Raw comparator results and counter clock arrive synchronous.
// Notes: Registers are reached over Avalon-MM with waitrequest.
// Operation
// R1: Raw result high when plus exceeds minus.
// R2: Polarity bits 5:4 invert reported outputs.
// R3: Eight modes; outputs unsettled after mode change.
// R4: Analog-assigned pins read back zero.
// R5: Bit 3 switches alternative input pins.
// R6: Output bits 7:6 are read only.
// R7: Routing puts raw results on pins.
// R8: Direction bits still enable pin drivers.
// R9: Gate select: pin when set, comparator2 clear.
// R10: Sync bit latches comparator2 on falling edge.
// R11: Latch uses prescaled counter clock.
// R12: Counter rises, latch falls, never together.
// R13: Software sets sync when comparator2 gates.
// R14: Output change sets its change flag.
// R15: Write zero clears flag, one sets.
// R16: Interrupt needs all three enables; flag regardless.
// R17: Mismatch keeps setting; main access recaptures.
// R18: Change during main read may lose flag.
// R19: Software disables interrupts during mode change.
// R20: Aux bits 7:2 read zero; reset 10.
// R21: Main control field layout, resets to zero.
// R22: Reset mode 000 disables; 111 turns off.
// R23: Per-mode pin routing from mapping table; here modes 1-6 share MODE_PINS1, or MODE_PINS2 with bit 3 set.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
module dcc_top #(
	parameter int SETTLE_CYCLES = dcc_pkg::SETTLE_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [1:0] raw_result_i,
	input wire logic [7:0] port_data_i,
	input wire logic [1:0] pin_direction_bit_i,
	input wire logic [1:0] port_out_i,
	input wire logic prescaled_clk_i,
	input wire logic external_gate_pin_i,
	output logic [1:0] output_pin_o,
	output logic [1:0] output_pin_oe_o,
	output logic [7:0] port_read_o,
	output logic counter_gate_o,
	output logic irq_o,
	output logic outputs_valid_o
);
	logic [5:0] main_reg;
	logic [1:0] aux_reg;
	logic [1:0] flag_reg;
	logic [4:0] ena_reg;
	logic [1:0] capt_reg;
	logic sync2_reg;
	logic pclk_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [15:0] settle_reg;
	logic [1:0] pin_reg;
	logic [1:0] pin_oe_reg;
	logic [7:0] port_reg;
	logic gate_reg;
	logic irq_reg;
	logic [1:0] result;
	logic [1:0] mismatch;
	logic [2:0] mode;
	logic off;
	logic fall;
	logic acc;
	logic wr_lo;
	logic hit_main;
	logic hit_aux;
	logic hit_flag;
	logic hit_ena;
	logic hit_pin;
	logic [7:0] analog_mask;
	logic [7:0] rd_byte;
	logic [1:0] flag_next;
	logic gate_src;

	assign mode = main_reg[2:0];
	assign off = (mode == dcc_pkg::MODE_RESET) || (mode == dcc_pkg::MODE_OFF);
	// Raw input already means plus above minus; inversion, and forced zero in modes 000 and 111. [R1] [R2]
	assign result = off ? 2'h0 : (raw_result_i ^ main_reg[5:4]);
	assign acc = (avs_read_i || avs_write_i) && !ack_reg;
	// A write acts on the edge at which waitrequest is seen low.
	assign wr_lo = avs_write_i && ack_reg && avs_byteenable_i[0];
	assign hit_main = avs_address_i == dcc_pkg::MAIN_ADDR;
	assign hit_aux = avs_address_i == dcc_pkg::AUX_ADDR;
	assign hit_flag = avs_address_i == dcc_pkg::FLAG_ADDR;
	assign hit_ena = avs_address_i == dcc_pkg::ENA_ADDR;
	assign hit_pin = avs_address_i == dcc_pkg::PIN_ADDR;
	// Reset mode claims all pins, off none, other modes a set; the switch adds one. [R5]
	assign analog_mask = (mode == dcc_pkg::MODE_RESET) ? 8'hff :
		(mode == dcc_pkg::MODE_OFF) ? 8'h00 :
		(main_reg[3] ? dcc_pkg::MODE_PINS2 : dcc_pkg::MODE_PINS1); // [R23]
	assign mismatch = result ^ capt_reg;
	// Hardware set wins over a software clear in the same cycle. [R14] [R15]
	assign flag_next = (wr_lo && hit_flag) ?
		(avs_writedata_i[6:5] | mismatch) : (flag_reg | mismatch);
	assign fall = pclk_reg && !prescaled_clk_i;
	// Pin when set, second comparator otherwise. [R9]
	assign gate_src = aux_reg[1] ? external_gate_pin_i :
		(aux_reg[0] ? sync2_reg : result[1]); // [R10]
	assign rd_byte = hit_main ? {capt_reg, main_reg} :
		hit_aux ? {6'h00, aux_reg} : // [R20]
		hit_flag ? {1'b0, flag_reg, 5'h00} :
		hit_ena ? {3'h0, ena_reg} :
		hit_pin ? port_reg : 8'h00;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			main_reg <= dcc_pkg::MAIN_RESET; // [R21] [R22]
			aux_reg <= dcc_pkg::AUX_RESET; // [R20]
			ena_reg <= 5'h00;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end
		else
		begin
			ack_reg <= acc;
			rdata_reg <= {24'h0, rd_byte};
			// Status bits 7:6 are never written. [R6] [R3]
			if (wr_lo && hit_main)
				main_reg <= avs_writedata_i[5:0];
			if (wr_lo && hit_aux)
				aux_reg <= avs_writedata_i[1:0];
			if (wr_lo && hit_ena)
				ena_reg <= avs_writedata_i[4:0];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			flag_reg <= 2'h0;
			capt_reg <= 2'h0;
		end
		else
		begin
			flag_reg <= flag_next; // [R14] [R15]
			// Only a main access ends the mismatch; a change landing in
			// that cycle still sets the flag before the capture absorbs it. [R17] [R18]
			if (acc && hit_main)
				capt_reg <= result;
		end
	end

	// Latch on the falling edge of the prescaled clock, which the counter
	// never uses for counting, so gate and increment never race. [R11] [R12]
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pclk_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end
		else
		begin
			pclk_reg <= prescaled_clk_i;
			if (fall)
				sync2_reg <= result[1]; // [R10] [R13]
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			settle_reg <= 16'h0;
		else if (wr_lo && hit_main && avs_writedata_i[2:0] != mode)
			settle_reg <= 16'(SETTLE_CYCLES); // [R3]
		else if (settle_reg != 16'h0)
			settle_reg <= settle_reg - 16'h1;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_reg <= 2'h0;
			pin_oe_reg <= 2'h0;
			port_reg <= 8'h00;
			gate_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else
		begin
			// Routed pins carry the unsynchronised results. [R7]
			pin_reg <= ena_reg[dcc_pkg::ENA_OE_POS] ? result : port_out_i;
			pin_oe_reg <= ~pin_direction_bit_i; // [R8]
			port_reg <= port_data_i & ~analog_mask; // [R4]
			gate_reg <= gate_src;
			irq_reg <= |(flag_next & ena_reg[4:3]) &&
				ena_reg[dcc_pkg::ENA_PERIPHERAL_IRQ_ENABLE_POS] &&
				ena_reg[dcc_pkg::ENA_GIE_POS]; // [R16]
		end
	end

	assign avs_waitrequest_o = !ack_reg;
	assign avs_readdata_o = rdata_reg;
	assign output_pin_o = pin_reg;
	assign output_pin_oe_o = pin_oe_reg;
	assign port_read_o = port_reg;
	assign counter_gate_o = gate_reg;
	assign irq_o = irq_reg;
	assign outputs_valid_o = settle_reg == 16'h0;

	flag_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(mismatch[0] && !ack_reg) |=> flag_reg[0]) // [R14]
		else $error("change did not set flag");
	clear_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_lo && hit_flag && !avs_writedata_i[5] && !mismatch[0])
		|=> !flag_reg[0]) // [R15]
		else $error("flag not cleared by zero write");
	irq_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		irq_o |-> $past(ena_reg[0]) && $past(ena_reg[1])) // [R16]
		else $error("irq without enables");
	aux_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(ack_reg && $past(hit_aux)) |-> avs_readdata_o[7:2] == 6'h0) // [R20]
		else $error("aux upper bits not zero");
	recapture_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(acc && hit_main) |=> capt_reg == $past(result)) // [R17]
		else $error("main access did not recapture");
	gate_pin_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		aux_reg[1] |=> counter_gate_o == $past(external_gate_pin_i)) // [R9]
		else $error("gate not from pin");
	sync_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!fall |=> $stable(sync2_reg)) // [R12]
		else $error("latch moved without falling edge");
	route_pin_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ena_reg[2] |=> output_pin_o == $past(result)) // [R7]
		else $error("routed pin wrong");
	oe_dir_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		1'b1 |=> output_pin_oe_o == ~$past(pin_direction_bit_i)) // [R8]
		else $error("oe ignores direction");
	analog_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(mode == 3'h0) |=> port_read_o == 8'h00) // [R4]
		else $error("analog pin read nonzero");
	status_ro_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(wr_lo && hit_main) |=> $stable(capt_reg)) // [R6]
		else $error("status write path");
endmodule : dcc_top

// ==== bench/dcc_far_model.sv ====
// Purpose: Comparator input levels and prescaled counter clock source.
// Assumes: Levels are unsigned codes; a higher code is a higher voltage.
// Notes: The counter clock stands still while run_i is low.
`timescale 1ns/100ps
module dcc_far_model (
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic [1:0][7:0] plus_i,
	input wire logic [1:0][7:0] minus_i,
	output logic [1:0] raw_o,
	output logic tclk_o
);
	logic [1:0] div_reg = 2'h0;
	assign raw_o[1] = plus_i[1] > minus_i[1];
	assign raw_o[0] = plus_i[0] > minus_i[0];
	always_ff @(posedge clk_i)
	begin
		if (run_i)
			div_reg <= div_reg + 2'h1;
	end
	assign tclk_o = div_reg[1];
endmodule : dcc_far_model

// ==== bench/testbench.sv ====
// Purpose: Register, flag, pin and gate checks of the comparator control.
// Assumes: One wait state per access, settle count shortened to 4.
// Notes: Outputs are sampled at clock edges before they update.
`timescale 1ns/100ps
module testbench;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [9:0] adr = 10'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, q;
	logic [1:0][7:0] plus = '0;
	logic [1:0][7:0] minus = {8'h50, 8'h50};
	logic [1:0] raw, opin, oe;
	logic [7:0] pread;
	logic wreq, tclk, gate, irq, valid;
	logic run = 1'b0;
	logic egate = 1'b0;
	logic [7:0] ens [4] = '{8'h0b, 8'h0a, 8'h09, 8'h13};
	int n_errors = 0;
	int n_tests = 0;
	always #5 clk_i = ~clk_i;
	dcc_far_model far (.clk_i(clk_i), .run_i(run), .plus_i(plus),
		.minus_i(minus), .raw_o(raw), .tclk_o(tclk));
	dcc_top #(.SETTLE_CYCLES(4)) uut (.clk_i(clk_i), .resetn_i(resetn_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(4'h1),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.raw_result_i(raw), .port_data_i(8'hff),
		.pin_direction_bit_i(2'b10), .port_out_i(2'b11),
		.prescaled_clk_i(tclk), .external_gate_pin_i(egate),
		.output_pin_o(opin), .output_pin_oe_o(oe), .port_read_o(pread),
		.counter_gate_o(gate), .irq_o(irq), .outputs_valid_o(valid));
	task end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h0, d};
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wreq !== 1'b0)
		begin
			n_errors++;
			end_of_test();
		end
	endtask : acc
	task rdc(input string nm, input logic [9:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, q);
	endtask : rdc
	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task setraw(input logic [1:0] r);
		@(posedge clk_i);
		plus <= {r[1] ? 8'h90 : 8'h10, r[0] ? 8'h90 : 8'h10};
	endtask : setraw
	// Runs the counter clock through one falling edge and stops it low,
	// so that no latch event slips in between two checks.
	task fall();
		int n;
		n = 0;
		@(posedge clk_i);
		run <= 1'b1;
		while (tclk !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		while (tclk !== 1'b0 && n < 40)
		begin
			@(posedge clk_i);
			n++;
		end
		run <= 1'b0;
		if (n >= 40)
		begin
			n_errors++;
			end_of_test();
		end
	endtask : fall
	initial
	begin
		tick(3);
		resetn_i <= 1'b1;
		rdc("aux", dcc_pkg::AUX_ADDR, 8'h02);
		rdc("main", dcc_pkg::MAIN_ADDR, 8'h00);
		rdc("hole", 10'h000, 8'h00);
		acc(1'b1, dcc_pkg::AUX_ADDR, 8'hff);
		rdc("aux", dcc_pkg::AUX_ADDR, 8'h03);
		acc(1'b1, dcc_pkg::MAIN_ADDR, 8'hc2);
		tick(1);
		chk("valid", 32'h0, {31'h0, valid});
		for (int i = 0; i < 20 && valid !== 1'b1; i++)
			@(posedge clk_i);
		chk("valid", 32'h1, {31'h0, valid});
		rdc("main", dcc_pkg::MAIN_ADDR, 8'h02);
		$display("test registers done");
		setraw(2'b01);
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b1, dcc_pkg::MAIN_ADDR, {2'b11, i[1:0], 4'h2});
			acc(1'b0, dcc_pkg::MAIN_ADDR, 8'h00);
			rdc("out", dcc_pkg::MAIN_ADDR, {2'b01 ^ i[1:0], i[1:0], 4'h2});
		end
		rdc("pins", dcc_pkg::PIN_ADDR, 8'hc3);
		chk("port", 32'hc3, {24'h0, pread});
		acc(1'b1, dcc_pkg::MAIN_ADDR, 8'h0a);
		rdc("pins", dcc_pkg::PIN_ADDR, 8'hc1);
		acc(1'b1, dcc_pkg::MAIN_ADDR, 8'h07);
		rdc("pins", dcc_pkg::PIN_ADDR, 8'hff);
		acc(1'b1, dcc_pkg::MAIN_ADDR, 8'h02);
		acc(1'b1, dcc_pkg::ENA_ADDR, 8'h04);
		tick(2);
		chk("opin", 32'h1, {30'h0, opin});
		chk("oe", 32'h1, {30'h0, oe});
		acc(1'b1, dcc_pkg::ENA_ADDR, 8'h00);
		tick(2);
		chk("opin", 32'h3, {30'h0, opin});
		$display("test outputs done");
		acc(1'b0, dcc_pkg::MAIN_ADDR, 8'h00);
		acc(1'b1, dcc_pkg::FLAG_ADDR, 8'h00);
		rdc("flag", dcc_pkg::FLAG_ADDR, 8'h00);
		setraw(2'b11);
		tick(3);
		rdc("flag", dcc_pkg::FLAG_ADDR, 8'h40);
		acc(1'b1, dcc_pkg::FLAG_ADDR, 8'h00);
		rdc("flag", dcc_pkg::FLAG_ADDR, 8'h40);
		acc(1'b0, dcc_pkg::MAIN_ADDR, 8'h00);
		acc(1'b1, dcc_pkg::FLAG_ADDR, 8'h00);
		rdc("flag", dcc_pkg::FLAG_ADDR, 8'h00);
		acc(1'b1, dcc_pkg::FLAG_ADDR, 8'h20);
		rdc("flag", dcc_pkg::FLAG_ADDR, 8'h20);
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b1, dcc_pkg::ENA_ADDR, ens[i]);
			tick(2);
			chk("irq", {31'h0, i == 0}, {31'h0, irq});
		end
		acc(1'b1, dcc_pkg::ENA_ADDR, 8'h00);
		$display("test flags done");
		egate <= 1'b1;
		acc(1'b1, dcc_pkg::AUX_ADDR, 8'h02);
		tick(2);
		chk("gate", 32'h1, {31'h0, gate});
		acc(1'b1, dcc_pkg::AUX_ADDR, 8'h00);
		tick(2);
		chk("gate", 32'h1, {31'h0, gate});
		acc(1'b1, dcc_pkg::AUX_ADDR, 8'h01);
		fall();
		setraw(2'b01);
		tick(4);
		chk("gate", 32'h1, {31'h0, gate});
		fall();
		tick(3);
		chk("gate", 32'h0, {31'h0, gate});
		$display("test gate done");
		end_of_test();
	end
endmodule : testbench
